//--- bsfx_pkg.sv
package bsfx_pkg;

  // register byte addresses
  localparam logic [11:0] CMD_ADDR    = 12'h000;
  localparam logic [11:0] FLAGS_ADDR  = 12'h004;
  localparam logic [11:0] RESULT_ADDR = 12'h008;
  localparam logic [11:0] SP_ADDR     = 12'h00c;
  localparam logic [11:0] IO_BASE     = 12'h020;

  // command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BIT_LSB  = 5;
  localparam int CMD_OPND_LSB = 8;
  localparam int CMD_IO_LSB   = 16;

  // result word fields
  localparam int RES_BUSY_BIT = 8;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] IO_RESET     = 8'h00;

  // timing counts, in clock cycles
  localparam int STACK_OP_CYCLES = 2;
  localparam int SIMPLE_OP_CYCLES = 1;

  typedef enum logic [4:0] {
    push_op, pop_op, io_bit_set_op, io_bit_clear_op,
    logic_left_shift_op, logic_right_shift_op,
    rotate_left_carry_op, rotate_right_carry_op, arith_right_shift_op,
    nibble_swap_op, flag_set_op, flag_clear_op,
    bit_to_transfer_op, transfer_to_bit_op,
    carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
    zero_set_op, zero_clear_op, global_irq_on_op, global_irq_off_op,
    sign_set_op, sign_clear_op, overflow_set_op, overflow_clear_op
  } bsfx_op_e;

  typedef struct packed {
    logic [2:0] io_index;
    logic [7:0] operand;
    logic [2:0] bit_index;
    logic [4:0] opcode;
  } bsfx_cmd_s;

endpackage

//--- bsfx_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - push stacks the source and pop returns the top, two cycles each, flags untouched.
// - the I/O bit-set forces bit b of I/O location P to one and leaves everything else alone.
// - the I/O bit-clear forces bit b of I/O location P to zero and leaves everything else alone.
// - logical left shift moves bit n to n+1, loads zero into bit 0 and updates Z, C, N and V.
// - logical right shift moves bit n+1 to n, loads zero into bit 7 and updates Z, C, N and V.
// - rotates go through carry: old carry enters one end, the bit leaving the other is carry.
// - arithmetic right shift moves bits down, keeps bit 7 and updates Z, C, N and V.
// - nibble swap exchanges the low and high four bits in one cycle with flags untouched.
// - generic flag set and clear write one or zero to status bit s only.
// - bit store copies source bit b into T; bit load copies T into bit b, flags untouched.
// - the carry instructions set or clear carry only.
// - the negative and zero instructions set or clear their own flag only.
// - global interrupt enable sets the I bit and disable clears it.
// - the sign and overflow instructions set or clear their own flag only.
// - every shift, rotate, swap, bit-transfer and flag instruction completes in one cycle.
module bsfx_unit #(
  parameter int STACK_DEPTH = 16,
  parameter int IO_COUNT    = 8
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  localparam int SPW = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {idle_st, exec_st, stack_st} bsfx_state_e;

  typedef struct packed {
    bsfx_state_e                          state;
    bsfx_pkg::bsfx_cmd_s                  cmd;
    logic [7:0]                           flags;
    logic [7:0]                           result;
    logic [SPW-1:0]                       sp;
    logic [STACK_DEPTH-1:0][7:0]          stack;
    logic [IO_COUNT-1:0][7:0]             io;
    logic [31:0]                          prdata;
    logic                                 pready;
    logic                                 pslverr;
  } bsfx_regs_s;

  bsfx_regs_s r;
  bsfx_regs_s next_r;

  // address decode: 0 cmd, 1 flags, 2 result, 3 sp, 4 io, 5 unmapped
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    if (addr == bsfx_pkg::CMD_ADDR) begin
      return 3'h0;
    end else if (addr == bsfx_pkg::FLAGS_ADDR) begin
      return 3'h1;
    end else if (addr == bsfx_pkg::RESULT_ADDR) begin
      return 3'h2;
    end else if (addr == bsfx_pkg::SP_ADDR) begin
      return 3'h3;
    end else if (addr >= bsfx_pkg::IO_BASE && addr[1:0] == 2'h0 &&
                 addr < bsfx_pkg::IO_BASE + 12'(4 * IO_COUNT)) begin
      return 3'h4;
    end
    return 3'h5;
  endfunction

  // shift result flags
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res,
                                             input logic c);
    logic [7:0] o;
    o = f;
    o[bsfx_pkg::FLAG_C] = c;
    o[bsfx_pkg::FLAG_Z] = (res == 8'h00);
    o[bsfx_pkg::FLAG_N] = res[7];
    o[bsfx_pkg::FLAG_V] = res[7] ^ c;
    return o;
  endfunction

  logic [2:0]  sel;
  logic [11:0] io_off;
  logic [2:0]  io_idx;
  logic        access;
  logic [7:0]  opnd;
  logic [2:0]  bidx;

  always_comb begin
    next_r  = r;
    sel     = reg_sel(PADDR);
    io_off  = PADDR - bsfx_pkg::IO_BASE;
    io_idx  = io_off[4:2];
    access  = PSEL && PENABLE && r.pready;
    opnd    = r.cmd.operand;
    bidx    = r.cmd.bit_index;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;

    // apb answer, held off while an instruction is running
    if (PSEL && PENABLE && !r.pready && r.state == idle_st) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = (sel == 3'h5);
      next_r.prdata  = 32'h0000_0000;
      case (sel)
        3'h0: begin
          next_r.prdata = 32'(r.cmd);
        end
        3'h1: begin
          next_r.prdata = {24'h00_0000, r.flags};
        end
        3'h2: begin
          next_r.prdata = {23'h00_0000, r.state != idle_st, r.result};
        end
        3'h3: begin
          next_r.prdata = 32'(r.sp);
        end
        3'h4: begin
          next_r.prdata = {24'h00_0000, r.io[io_idx]};
        end
        default: begin
          next_r.prdata = 32'h0000_0000;
        end
      endcase
    end

    // apb write on the sampled edge
    if (access && PWRITE) begin
      case (sel)
        3'h0: begin
          next_r.cmd   = bsfx_pkg::bsfx_cmd_s'(PWDATA[18:0]);
          next_r.state = exec_st;
        end
        3'h1: begin
          next_r.flags = PWDATA[7:0];
        end
        3'h4: begin
          next_r.io[io_idx] = PWDATA[7:0];
        end
        default: begin
        end
      endcase
    end

    case (r.state)
      idle_st: begin
      end
      exec_st: begin
        next_r.state = idle_st;
        case (bsfx_pkg::bsfx_op_e'(r.cmd.opcode))
          bsfx_pkg::push_op: begin
            next_r.stack[r.sp] = opnd;
            next_r.state       = stack_st;
          end
          bsfx_pkg::pop_op: begin
            next_r.sp    = r.sp + SPW'(1);
            next_r.state = stack_st;
          end
          bsfx_pkg::io_bit_set_op: begin
            next_r.io[r.cmd.io_index][bidx] = 1'b1;
          end
          bsfx_pkg::io_bit_clear_op: begin
            next_r.io[r.cmd.io_index][bidx] = 1'b0;
          end
          bsfx_pkg::logic_left_shift_op: begin
            next_r.result = {opnd[6:0], 1'b0};
            next_r.flags  = shift_flags(r.flags, {opnd[6:0], 1'b0}, opnd[7]);
          end
          bsfx_pkg::logic_right_shift_op: begin
            next_r.result = {1'b0, opnd[7:1]};
            next_r.flags  = shift_flags(r.flags, {1'b0, opnd[7:1]}, opnd[0]);
          end
          bsfx_pkg::rotate_left_carry_op: begin
            next_r.result = {opnd[6:0], r.flags[bsfx_pkg::FLAG_C]};
            next_r.flags  = shift_flags(r.flags, {opnd[6:0], r.flags[bsfx_pkg::FLAG_C]},
                                        opnd[7]);
          end
          bsfx_pkg::rotate_right_carry_op: begin
            next_r.result = {r.flags[bsfx_pkg::FLAG_C], opnd[7:1]};
            next_r.flags  = shift_flags(r.flags, {r.flags[bsfx_pkg::FLAG_C], opnd[7:1]},
                                        opnd[0]);
          end
          bsfx_pkg::arith_right_shift_op: begin
            next_r.result = {opnd[7], opnd[7:1]};
            next_r.flags  = shift_flags(r.flags, {opnd[7], opnd[7:1]}, opnd[0]);
          end
          bsfx_pkg::nibble_swap_op: begin
            next_r.result = {opnd[3:0], opnd[7:4]};
          end
          bsfx_pkg::flag_set_op: begin
            next_r.flags[bidx] = 1'b1;
          end
          bsfx_pkg::flag_clear_op: begin
            next_r.flags[bidx] = 1'b0;
          end
          bsfx_pkg::bit_to_transfer_op: begin
            next_r.flags[bsfx_pkg::FLAG_T] = opnd[bidx];
          end
          bsfx_pkg::transfer_to_bit_op: begin
            next_r.result       = opnd;
            next_r.result[bidx] = r.flags[bsfx_pkg::FLAG_T];
          end
          bsfx_pkg::carry_set_op: begin
            next_r.flags[bsfx_pkg::FLAG_C] = 1'b1;
          end
          bsfx_pkg::carry_clear_op: begin
            next_r.flags[bsfx_pkg::FLAG_C] = 1'b0;
          end
          bsfx_pkg::negative_set_op: begin
            next_r.flags[bsfx_pkg::FLAG_N] = 1'b1;
          end
          bsfx_pkg::negative_clear_op: begin
            next_r.flags[bsfx_pkg::FLAG_N] = 1'b0;
          end
          bsfx_pkg::zero_set_op: begin
            next_r.flags[bsfx_pkg::FLAG_Z] = 1'b1;
          end
          bsfx_pkg::zero_clear_op: begin
            next_r.flags[bsfx_pkg::FLAG_Z] = 1'b0;
          end
          bsfx_pkg::global_irq_on_op: begin
            next_r.flags[bsfx_pkg::FLAG_I] = 1'b1;
          end
          bsfx_pkg::global_irq_off_op: begin
            next_r.flags[bsfx_pkg::FLAG_I] = 1'b0;
          end
          bsfx_pkg::sign_set_op: begin
            next_r.flags[bsfx_pkg::FLAG_S] = 1'b1;
          end
          bsfx_pkg::sign_clear_op: begin
            next_r.flags[bsfx_pkg::FLAG_S] = 1'b0;
          end
          bsfx_pkg::overflow_set_op: begin
            next_r.flags[bsfx_pkg::FLAG_V] = 1'b1;
          end
          bsfx_pkg::overflow_clear_op: begin
            next_r.flags[bsfx_pkg::FLAG_V] = 1'b0;
          end
          default: begin
          end
        endcase
      end
      stack_st: begin
        next_r.state = idle_st;
        if (bsfx_pkg::bsfx_op_e'(r.cmd.opcode) == bsfx_pkg::push_op) begin
          next_r.sp = r.sp - SPW'(1);
        end else begin
          next_r.result = r.stack[r.sp];
        end
      end
      default: begin
        next_r.state = idle_st;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      r         <= '0;
      r.state   <= idle_st;
      r.flags   <= bsfx_pkg::FLAGS_RESET;
      r.result  <= bsfx_pkg::RESULT_RESET;
      r.sp      <= SPW'(STACK_DEPTH - 1);
      r.io      <= {IO_COUNT{bsfx_pkg::IO_RESET}};
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA  = r.prdata;
  assign PREADY  = r.pready;
  assign PSLVERR = r.pslverr;

endmodule // bsfx_unit

//--- bsfx_checker.sv
`timescale 1ns/100ps
module bsfx_checker #(
  parameter int STACK_DEPTH = 16,
  parameter int IO_COUNT    = 8
) (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  logic mapped;
  assign mapped = PADDR[1:0] == 2'h0 && (PADDR <= bsfx_pkg::SP_ADDR ||
    (PADDR >= bsfx_pkg::IO_BASE && PADDR < bsfx_pkg::IO_BASE + 12'(4 * IO_COUNT)));
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without an access phase");
  a_answer_bound: assert property ($rose(PENABLE) && PSEL |-> ##[1:3] PREADY)
    else $error("access not answered within three cycles");
  a_simple_fast: assert property ((PREADY && PWRITE && PADDR == bsfx_pkg::CMD_ADDR
    && PWDATA[4:0] > 5'h01) ##1 (PSEL && !PENABLE) ##1 PENABLE |=> PREADY)
    else $error("single cycle command stalled the bus");
  a_stack_slow: assert property ((PREADY && PWRITE && PADDR == bsfx_pkg::CMD_ADDR
    && PWDATA[4:0] <= 5'h01) ##1 (PSEL && !PENABLE) ##1 PENABLE |=> !PREADY ##1 PREADY)
    else $error("stack command did not take two cycles");
  a_unmapped_err: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  a_upper_zero: assert property (PREADY && !PWRITE && PADDR != bsfx_pkg::CMD_ADDR
    |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_sp_range: assert property (PREADY && !PWRITE && PADDR == bsfx_pkg::SP_ADDR
    |-> PRDATA < STACK_DEPTH)
    else $error("stack index out of range");
endmodule // bsfx_checker

bind bsfx_unit bsfx_checker #(.STACK_DEPTH(STACK_DEPTH), .IO_COUNT(IO_COUNT)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

//--- bit_shift_flag_execution_unit_tb_top.sv
`timescale 1ns/100ps
module bit_shift_flag_execution_unit_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          seed = 32'h940b90b1;
  int          bpos [6] = '{bsfx_pkg::FLAG_C, bsfx_pkg::FLAG_N, bsfx_pkg::FLAG_Z,
                             bsfx_pkg::FLAG_I, bsfx_pkg::FLAG_S, bsfx_pkg::FLAG_V};
  logic [7:0]  fl;
  logic [7:0]  io [8];
  logic [7:0]  stk [$];
  logic [31:0] r;
  logic [31:0] v;
  logic        e;

  always #2 clk = ~clk;

  bsfx_unit uut (
    .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  task conclude;
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // setup, access, wait for ready, take data at the sampling edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
  endtask

  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  task run(input int op, input logic [2:0] b, input logic [7:0] d, input logic [2:0] p);
    logic [7:0] res;
    logic       c;
    c = fl[bsfx_pkg::FLAG_C];
    res = 8'h00;
    case (op)
      0: stk.push_back(d);
      1: res = stk.pop_back();
      2: io[p][b] = 1'b1;
      3: io[p][b] = 1'b0;
      4: {c, res} = {d, 1'b0};
      5: {res, c} = {1'b0, d};
      6: {c, res} = {d, c};
      7: {res, c} = {c, d};
      8: {res, c} = {d[7], d};
      9: res = {d[3:0], d[7:4]};
      10, 11: fl[b] = (op == 10);
      12: fl[bsfx_pkg::FLAG_T] = d[b];
      13: begin
        res = d;
        res[b] = fl[bsfx_pkg::FLAG_T];
      end
      default: fl[bpos[(op - 14) / 2]] = !op[0];
    endcase
    if (op inside {[4:8]})
      fl[3:0] = {res[7] ^ c, res[7], res == 8'h00, c};
    apb(1'b1, bsfx_pkg::CMD_ADDR, {13'h0, p, d, b, 5'(op)});
    rdchk(bsfx_pkg::FLAGS_ADDR, {24'h0, fl});
    if (op inside {1, [4:9], 13})
      rdchk(bsfx_pkg::RESULT_ADDR, {24'h0, res});
    if (op inside {2, 3})
      rdchk(bsfx_pkg::IO_BASE + 12'(4 * p), {24'h0, io[p]});
    if (op < 2)
      rdchk(bsfx_pkg::SP_ADDR, 32'(15 - stk.size()));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    int op;
    fl = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(bsfx_pkg::FLAGS_ADDR, 32'h0);
    rdchk(bsfx_pkg::SP_ADDR, 32'd15);
    for (int i = 0; i < 8; i++) begin
      rdchk(bsfx_pkg::IO_BASE + 12'(4 * i), 32'h0);
      v = $random(seed);
      io[i] = v[7:0];
      apb(1'b1, bsfx_pkg::IO_BASE + 12'(4 * i), {24'h0, io[i]});
    end
    // unmapped places are refused
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, 12'h040, 32'h0);
    chk({31'h0, e}, 32'h1);
    v = $random(seed);
    fl = v[7:0];
    apb(1'b1, bsfx_pkg::FLAGS_ADDR, {24'h0, fl});
    // every opcode once, then random ones back to back
    for (int i = 0; i < 326; i++) begin
      v = $random(seed);
      op = (i < 26) ? i : int'(v[31:24] % 26);
      if (op == 0 && stk.size() > 14)
        op = 1;
      if (op == 1 && stk.size() == 0)
        op = 0;
      run(op, v[2:0], v[15:8], v[18:16]);
    end
    idle();
    conclude();
  end
endmodule // bit_shift_flag_execution_unit_tb_top
